// file: hdl/ieq_error_queue.sv
// Error record queue: intake FIFO, twenty-entry store and query answer.
// Function
// [R1] Each query returns one record and removes it.
// [R2] Store holds at most twenty records.
// [R3] Records leave oldest first.
// [R4] Error arriving when full overwrites newest record with code -350.
// [R5] After overflow, further errors are dropped until a query removes one.
// [R6] Query on empty queue answers +0, no error, and changes nothing.
// [R7] Answer is signed code plus text id, response at most 255 chars.
// [R8] One beep request per syntax or hardware error recorded; the code also beeps for such errors dropped after overflow.
// [R9] Summary flag toward status byte shows pending errors.
// [R10] Clear-status and power-up empty the queue; factory reset does not.
// [R11] Beep only sounds while the beeper enable setting is on.
// [R12] Summary flag follows non-empty state the same cycle.
`timescale 1ns/1ps
`default_nettype none
module ieq_error_queue (
  // Clock and power-up reset
  input wire logic clock,
  input wire logic rst,
  // Error sources
  input wire logic err_valid,
  output logic err_ready,
  input wire logic [ieq_pkg::CODE_W-1:0] err_code,
  input wire logic [ieq_pkg::TEXT_W-1:0] err_text,
  input wire ieq_pkg::ieq_src_t err_src,
  // Commands from the remote interface
  input wire logic query,
  input wire logic clear_status,
  input wire logic factory_reset,
  // Setting held in nonvolatile storage
  input wire logic beeper_enable,
  // Answer to the query
  output logic resp_valid,
  output logic [ieq_pkg::CODE_W-1:0] resp_code,
  output logic [ieq_pkg::TEXT_W-1:0] resp_text,
  output logic [7:0] resp_max_len,
  // Indications
  output logic beep,
  output logic err_summary
);
  ieq_stream_if in_s ();
  ieq_stream_if out_s ();

  logic [ieq_pkg::REC_W-1:0] store [ieq_pkg::QUEUE_DEPTH];
  logic [ieq_pkg::CNT_W-1:0] head_reg, head_next, cnt_reg, cnt_next;
  logic ovf_reg, ovf_next;
  logic resp_valid_reg, resp_valid_next;
  logic [ieq_pkg::CODE_W-1:0] resp_code_reg, resp_code_next;
  logic [ieq_pkg::TEXT_W-1:0] resp_text_reg, resp_text_next;
  logic beep_reg, beep_next;
  logic take, remove, wr_en;
  logic [ieq_pkg::CNT_W-1:0] wr_idx;
  logic [ieq_pkg::REC_W-1:0] wr_data;

  // Index into the circular store, wrapping at twenty.
  function automatic logic [ieq_pkg::CNT_W-1:0] wrap_add(
    input logic [ieq_pkg::CNT_W-1:0] a,
    input logic [ieq_pkg::CNT_W-1:0] b
  );
    logic [ieq_pkg::CNT_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, ieq_pkg::CNT_FULL}) begin
      s = s - {1'b0, ieq_pkg::CNT_FULL};
    end
    return s[ieq_pkg::CNT_W-1:0];
  endfunction

  // -----------------------------------------------------------
  // Intake buffer
  // -----------------------------------------------------------
  // The FIFO absorbs bursts; its ready stalls the error sources.
  assign in_s.valid = err_valid;
  assign in_s.data = {err_code, err_text};
  assign err_ready = in_s.ready;

  ieq_fifo #(
    .WIDTH(ieq_pkg::REC_W),
    .DEPTH(ieq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .flush(clear_status),
    .in_s(in_s),
    .out_s(out_s)
  );

  // The store drains the buffer only on cycles free of queries, so
  // a query and an arrival never race for the same slot.
  assign out_s.ready = !query && !clear_status;
  assign take = out_s.valid && out_s.ready;
  assign remove = query && !clear_status && (cnt_reg != '0); // R1 R6

  // -----------------------------------------------------------
  // Store control
  // -----------------------------------------------------------
  // A full store turns the newest slot into the overflow record.
  always_comb begin
    head_next = head_reg;
    cnt_next = cnt_reg;
    ovf_next = ovf_reg;
    wr_en = 1'b0;
    wr_idx = wrap_add(head_reg, cnt_reg);
    wr_data = out_s.data;
    if (clear_status) begin
      head_next = ieq_pkg::CNT_RESET; // R10
      cnt_next = ieq_pkg::CNT_RESET; // R10
      ovf_next = 1'b0;
    end else if (remove) begin
      head_next = wrap_add(head_reg, 5'h01); // R3
      cnt_next = cnt_reg - 5'h01; // R1
      ovf_next = 1'b0; // R5
    end else if (take) begin
      if (cnt_reg != ieq_pkg::CNT_FULL) begin
        wr_en = 1'b1;
        cnt_next = cnt_reg + 5'h01; // R2
      end else if (!ovf_reg) begin
        wr_en = 1'b1; // R4
        wr_idx = wrap_add(head_reg, ieq_pkg::CNT_FULL - 5'h01); // R4
        wr_data = {ieq_pkg::CODE_OVERFLOW, ieq_pkg::TEXT_OVERFLOW}; // R4
        ovf_next = 1'b1; // R5
      end
    end
  end

  // Factory reset is deliberately ignored by the store.
  always_ff @(posedge clock) begin
    if (rst) begin
      head_reg <= ieq_pkg::CNT_RESET; // R10
      cnt_reg <= ieq_pkg::CNT_RESET; // R10
      ovf_reg <= 1'b0;
    end else begin
      head_reg <= head_next;
      cnt_reg <= cnt_next;
      ovf_reg <= ovf_next;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_en) begin
      store[wr_idx] <= wr_data;
    end
  end

  // -----------------------------------------------------------
  // Source classes beside the intake buffer
  // -----------------------------------------------------------
  // The buffer carries only code and text, so the class of each record
  // waits here in step with it. Without this, a beep would follow the
  // class that the sources show when the record leaves the buffer.
  localparam int SAW = $clog2(ieq_pkg::FIFO_DEPTH);
  ieq_pkg::ieq_src_t src_mem [ieq_pkg::FIFO_DEPTH];
  logic [SAW-1:0] src_wr_reg, src_wr_next, src_rd_reg, src_rd_next;
  logic src_push;
  ieq_pkg::ieq_src_t take_src;

  // Step a class pointer, wrapping after the last buffer slot.
  function automatic logic [SAW-1:0] tag_step(input logic [SAW-1:0] p);
    return (p == SAW'(ieq_pkg::FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Mirrors the buffer's own push; a flush discards the offer.
  assign src_push = in_s.valid && in_s.ready && !clear_status;
  assign take_src = src_mem[src_rd_reg]; // R8

  // Class pointers follow the buffer's push, pop and flush.
  always_comb begin
    src_wr_next = src_wr_reg;
    src_rd_next = src_rd_reg;
    if (clear_status) begin
      src_wr_next = '0; // R10
      src_rd_next = '0; // R10
    end else begin
      if (src_push) begin
        src_wr_next = tag_step(src_wr_reg);
      end
      if (take) begin
        src_rd_next = tag_step(src_rd_reg);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      src_wr_reg <= '0;
      src_rd_reg <= '0;
    end else begin
      src_wr_reg <= src_wr_next;
      src_rd_reg <= src_rd_next;
    end
  end

  // No reset is needed; a slot is read only after it was written.
  always_ff @(posedge clock) begin
    if (src_push) begin
      src_mem[src_wr_reg] <= err_src;
    end
  end

  // -----------------------------------------------------------
  // Answer and indications
  // -----------------------------------------------------------
  // The answer is registered one cycle after the query.
  always_comb begin
    resp_valid_next = query && !clear_status;
    resp_code_next = resp_code_reg;
    resp_text_next = resp_text_reg;
    if (remove) begin
      resp_code_next = store[head_reg][ieq_pkg::REC_W-1:ieq_pkg::TEXT_W]; // R7
      resp_text_next = store[head_reg][ieq_pkg::TEXT_W-1:0]; // R7
    end else if (resp_valid_next) begin
      resp_code_next = ieq_pkg::CODE_NO_ERROR; // R6
      resp_text_next = ieq_pkg::TEXT_NO_ERROR; // R6
    end
    // One pulse per syntax or hardware error taken from the buffer, whether
    // stored or dropped at overflow, judged by the class that travelled with it.
    beep_next = take && beeper_enable && // R11
      (take_src == ieq_pkg::IEQ_SRC_SYNTAX ||
       take_src == ieq_pkg::IEQ_SRC_HARDWARE); // R8
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      resp_valid_reg <= 1'b0;
      resp_code_reg <= ieq_pkg::CODE_NO_ERROR;
      resp_text_reg <= ieq_pkg::TEXT_NO_ERROR;
      beep_reg <= 1'b0;
    end else begin
      resp_valid_reg <= resp_valid_next;
      resp_code_reg <= resp_code_next;
      resp_text_reg <= resp_text_next;
      beep_reg <= beep_next;
    end
  end

  assign resp_valid = resp_valid_reg;
  assign resp_code = resp_code_reg;
  assign resp_text = resp_text_reg;
  assign resp_max_len = 8'(ieq_pkg::MAX_RESP_CHARS); // R7
  assign beep = beep_reg;
  // Registered count, so the flag rises with the stored record.
  assign err_summary = (cnt_reg != '0); // R9 R12
  // Factory reset is accepted but has no effect on the queue.
  logic unused_ok;
  assign unused_ok = factory_reset; // R10
endmodule
`default_nettype wire

// file: hdl/ieq_fifo.sv
// Parameterised valid/ready FIFO that buffers incoming error records.
`timescale 1ns/1ps
`default_nettype none
module ieq_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic flush,
  // Streams
  ieq_stream_if.snk in_s,
  ieq_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // -----------------------------------------------------------
  // Handshakes
  // -----------------------------------------------------------
  // Full and empty come straight from the occupancy count.
  assign in_s.ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_reg != '0);
  assign out_s.data = mem[rd_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // Pointer and count update; flush wins over all traffic.
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (flush) begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end else begin
      if (push) begin
        wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; only written slots are ever read.
  always_ff @(posedge clock) begin
    if (push && !flush) begin
      mem[wr_reg] <= in_s.data;
    end
  end
endmodule
`default_nettype wire

// file: hdl/ieq_pkg.sv
// Package of constants and types for the instrument error queue.
package ieq_pkg;

  // ------------------------------------------------------------
  // Record layout
  // ------------------------------------------------------------
  localparam int CODE_W = 16;
  localparam int TEXT_W = 8;
  localparam int REC_W = CODE_W + TEXT_W;
  localparam int QUEUE_DEPTH = 20;
  localparam int CNT_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int MAX_RESP_CHARS = 255;

  // ------------------------------------------------------------
  // Codes, values after reset and full count
  // ------------------------------------------------------------
  localparam logic signed [CODE_W-1:0] CODE_NO_ERROR = 16'sh0000;
  localparam logic signed [CODE_W-1:0] CODE_OVERFLOW = -16'sd350;
  localparam logic [TEXT_W-1:0] TEXT_NO_ERROR = 8'h00;
  localparam logic [TEXT_W-1:0] TEXT_OVERFLOW = 8'hff;
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h14;

  // ------------------------------------------------------------
  // Error source classes and answer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    IEQ_SRC_OTHER,
    IEQ_SRC_SYNTAX,
    IEQ_SRC_HARDWARE
  } ieq_src_t;

  typedef enum logic [1:0] {
    IEQ_IDLE,
    IEQ_ANSWER
  } ieq_state_t;

endpackage

// file: hdl/ieq_stream_if.sv
// Interface carrying a valid/ready record stream between queue modules.
`timescale 1ns/1ps
`default_nettype none
interface ieq_stream_if;
  logic valid;
  logic ready;
  logic [ieq_pkg::REC_W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: verif/ieq_error_queue_properties.sv
// Concurrent checks on the ports of the error queue.
`timescale 1ns/1ps
`default_nettype none
module ieq_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requests
  input wire logic err_valid,
  input wire logic err_ready,
  input wire logic query,
  input wire logic clear_status,
  input wire logic beeper_enable,
  // Answers and indications
  input wire logic resp_valid,
  input wire logic [ieq_pkg::CODE_W-1:0] resp_code,
  input wire logic [ieq_pkg::TEXT_W-1:0] resp_text,
  input wire logic [7:0] resp_max_len,
  input wire logic beep,
  input wire logic err_summary
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_ANSWER: assert property (query && !clear_status |=> resp_valid)
    else $error("query not answered");
  AST_NO_ANSWER: assert property (!query |=> !resp_valid)
    else $error("answer without query");
  AST_EMPTY_CODE: assert property (query && !err_summary && !clear_status
    |=> resp_code == 16'h0000 && resp_text == 8'h00)
    else $error("empty answer not zero");
  AST_EMPTY_KEEP: assert property (query && !err_summary |=> !err_summary)
    else $error("empty query changed queue");
  AST_CLEAR: assert property (clear_status |=> !err_summary)
    else $error("clear left records");
  AST_SUMMARY_RISE: assert property (err_valid && err_ready && !clear_status
    ##1 !query && !clear_status |=> err_summary)
    else $error("summary late");
  AST_BEEP_GATE: assert property (beep |-> $past(beeper_enable))
    else $error("beep while disabled");
  AST_MAX_LEN: assert property (resp_max_len == 8'hff)
    else $error("bad length limit");

  // Main scenarios worth seeing.
  cover property (resp_valid && resp_code == ieq_pkg::CODE_OVERFLOW);
  cover property (beep);
  cover property (query && err_summary);
endmodule
bind ieq_error_queue ieq_properties chk_u (.clock, .rst, .err_valid,
  .err_ready, .query, .clear_status, .beeper_enable, .resp_valid,
  .resp_code, .resp_text, .resp_max_len, .beep, .err_summary);
`default_nettype wire

// file: verif/ieq_host_model.sv
// Remote host model that issues error queries and takes the answers.
`timescale 1ns/1ps
`default_nettype none
module ieq_host_model (
  // Clock and stall request
  input wire logic clock,
  input wire logic hold,
  // Query side
  output logic query,
  input wire logic resp_valid,
  input wire logic [ieq_pkg::CODE_W-1:0] resp_code,
  input wire logic [ieq_pkg::TEXT_W-1:0] resp_text
);
  logic pulse = 1'b0;
  // A held request queries every cycle, which stalls the store drain.
  assign query = pulse | hold;

  // One query; the answer stands one cycle, so it is taken right then.
  task automatic poll(output logic [23:0] ans, output logic ok);
    @(negedge clock);
    pulse = 1'b1;
    @(negedge clock);
    pulse = 1'b0;
    ans = {resp_code, resp_text};
    ok = resp_valid;
  endtask
endmodule
`default_nettype wire

// file: verif/instrument_error_queue_test.sv
// Self-checking bench for the instrument error queue.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module instrument_error_queue_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic err_valid = 1'b0;
  logic [15:0] err_code = 16'h0000;
  logic [7:0] err_text = 8'h00;
  ieq_pkg::ieq_src_t err_src = ieq_pkg::IEQ_SRC_OTHER;
  logic clear_status = 1'b0;
  logic factory_reset = 1'b0;
  logic beeper_enable = 1'b1;
  logic hold = 1'b0;
  logic err_ready, query, resp_valid, beep, err_summary, ok;
  logic [15:0] resp_code;
  logic [7:0] resp_text, resp_max_len;
  logic [23:0] ans, x;
  logic [23:0] q[$];
  logic ovf = 1'b0;
  int errors = 0, n_tests = 0, cyc = 0, nbeep = 0, xbeep = 0, k;

  always #2 clock = ~clock;

  ieq_error_queue dut_u (.clock, .rst, .err_valid, .err_ready, .err_code,
    .err_text, .err_src, .query, .clear_status, .factory_reset,
    .beeper_enable, .resp_valid, .resp_code, .resp_text, .resp_max_len,
    .beep, .err_summary);
  ieq_host_model host_u (.clock, .hold, .query, .resp_valid, .resp_code,
    .resp_text);

  // Count beeps, and cut a hang short well past the expected run.
  always @(posedge clock) begin
    cyc++;
    if (beep === 1'b1) nbeep++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  // Reference store: a full store takes the overflow mark only once.
  task automatic model_rec(logic [23:0] r);
    if (q.size() < 20) q.push_back(r);
    else if (!ovf) begin
      q[19] = {ieq_pkg::CODE_OVERFLOW, ieq_pkg::TEXT_OVERFLOW};
      ovf = 1'b1;
    end
  endtask

  // Offer random errors one at a time and let each reach the store.
  task automatic push(int n);
    repeat (n) begin
      @(negedge clock);
      err_code = 16'(-(1 + $urandom % 400));
      err_text = 8'($urandom);
      err_src = ieq_pkg::ieq_src_t'($urandom % 3);
      err_valid = 1'b1;
      @(negedge clock);
      err_valid = 1'b0;
      if (err_src != ieq_pkg::IEQ_SRC_OTHER && beeper_enable) xbeep++;
      model_rec({err_code, err_text});
      @(negedge clock);
      `CHK("summary", q.size() > 0, err_summary)
    end
  endtask

  // Query n times and compare with the reference store.
  task automatic drain(int n);
    repeat (n) begin
      host_u.poll(ans, ok);
      `CHK("answered", 1'b1, ok)
      x = {ieq_pkg::CODE_NO_ERROR, ieq_pkg::TEXT_NO_ERROR};
      if (q.size() > 0) begin
        x = q.pop_front();
        ovf = 1'b0;
      end
      `CHK("record", x, ans)
      `CHK("summary", q.size() > 0, err_summary)
    end
  endtask

  task automatic done(string s);
    `CHK("beeps", xbeep, nbeep)
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence; inputs change on the falling edge only.
  initial begin
    void'($urandom(32'hb3bc));
    repeat (12) @(negedge clock);
    rst = 1'b0;
    `CHK("max length", 8'hff, resp_max_len)
    drain(1);
    done("empty");
    push(3);
    drain(4);
    done("order");
    beeper_enable = 1'b0;
    push(22);
    drain(1);
    push(2);
    drain(21);
    done("overflow");
    beeper_enable = 1'b1;
    push(2);
    factory_reset = 1'b1;
    @(negedge clock);
    factory_reset = 1'b0;
    `CHK("kept", 1'b1, err_summary)
    clear_status = 1'b1;
    @(negedge clock);
    clear_status = 1'b0;
    q.delete();
    `CHK("cleared", 1'b0, err_summary)
    drain(1);
    done("clear");
    // Stall the drain with held queries for twenty offers, past the point where the intake refuses; the
    // classes change while stalled, so each beep must follow its record.
    hold = 1'b1;
    k = 0;
    repeat (20) begin
      @(negedge clock);
      err_code = 16'(k + 1);
      err_src = ieq_pkg::ieq_src_t'($urandom % 3);
      err_valid = 1'b1;
      // Ready depends only on the buffer fill, so it is settled here.
      if (err_ready === 1'b1) begin
        model_rec({err_code, err_text});
        if (err_src != ieq_pkg::IEQ_SRC_OTHER && beeper_enable) xbeep++;
        k++;
      end
    end
    @(negedge clock);
    err_valid = 1'b0;
    hold = 1'b0;
    `CHK("fifo depth", 16, k)
    repeat (20) @(negedge clock);
    drain(17);
    done("fifo");
    tally_and_finish();
  end
endmodule
`default_nettype wire
